/* verilog/see_ctrl.v */
// two-wire serial memory slave: addressing, page write, reads, write cycle timer
`default_nettype none
`include "see_defines.vh"

module see_ctrl #(
    parameter integer TWR_CYCLES = `SEE_TWR_US * `SEE_CLK_MHZ
) (
    input  wire       I_CLK_SYS,
    input  wire       I_SYS_RST,
    input  wire       I_SCL,
    input  wire       I_SDA,
    input  wire [2:0] I_ADDRESS_SELECT_STRAPS,
    output wire       O_SDA_OUT,
    output wire       O_SDA_OE,
    output wire       O_WRITE_BUSY
);

    // ==========================================================
    // states
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_DEV  = 3'd1;
    localparam [2:0] ST_AHI  = 3'd2;
    localparam [2:0] ST_ALO  = 3'd3;
    localparam [2:0] ST_WDAT = 3'd4;
    localparam [2:0] ST_RDAT = 3'd5;

    // R16 address match
    function dev_match;
        input [7:0] b;
        input [2:0] straps;
        begin
            dev_match = (b[7:4] == `SEE_DEV_PREFIX) && (b[3:1] == straps);
        end
    endfunction

    // ==========================================================
    // input synchronisers
    // bits: 0 scl, 1 sda, 4:2 straps; a level counts once stages two and three agree
    wire [4:0] pin_in = {I_ADDRESS_SELECT_STRAPS, I_SDA, I_SCL};
    reg  [4:0] s1_r;
    reg  [4:0] s2_r;
    reg  [4:0] s3_r;
    reg  [4:0] filt_r;
    reg  [1:0] filt_d_r;

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_sync
            always @(posedge I_CLK_SYS) begin
                if (I_SYS_RST) begin
                    s1_r[g]   <= 1'b1;
                    s2_r[g]   <= 1'b1;
                    s3_r[g]   <= 1'b1;
                    filt_r[g] <= 1'b1;
                end else begin
                    s1_r[g] <= pin_in[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                    if (s2_r[g] == s3_r[g]) begin
                        filt_r[g] <= s3_r[g];
                    end
                end
            end
        end
    endgenerate

    always @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            filt_d_r <= 2'b11;
        end else begin
            filt_d_r <= filt_r[1:0];
        end
    end

    wire scl      = filt_r[0];
    wire sda      = filt_r[1];
    wire scl_rise = scl & ~filt_d_r[0];
    wire scl_fall = ~scl & filt_d_r[0];
    // start and stop only count while the clock stays high on both samples
    wire start_ev = scl & filt_d_r[0] & ~sda & filt_d_r[1];
    wire stop_ev  = scl & filt_d_r[0] & sda & ~filt_d_r[1];

    // ==========================================================
    // storage and state
    reg [7:0]  mem [0:`SEE_MEM_DEPTH-1];
    reg [2:0]  st_r;
    reg [3:0]  bit_r;
    reg [7:0]  sh_r;
    reg [7:0]  rd_r;
    reg [15:0] addr_r;
    reg        mack_r;
    reg        wr_pend_r;
    reg        busy_r;
    reg [31:0] twr_cnt_r;
    reg        oe_r;
    reg        sda_o_r;

    assign O_SDA_OUT    = sda_o_r;
    assign O_SDA_OE     = oe_r;
    assign O_WRITE_BUSY = busy_r;

    wire [7:0] rd_next = mem[addr_r];

    // ==========================================================
    // memory write port
    always @(posedge I_CLK_SYS) begin
        if (!I_SYS_RST && !busy_r && scl_fall && !start_ev && !stop_ev
            && st_r == ST_WDAT && bit_r == `SEE_BIT_ACK) begin
            mem[addr_r] <= sh_r;
        end
    end

    // ==========================================================
    // protocol engine
    always @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            st_r      <= ST_IDLE;
            bit_r     <= 4'h0;
            sh_r      <= 8'h00;
            rd_r      <= 8'h00;
            addr_r    <= `SEE_ADDR_RST;
            mack_r    <= 1'b1;
            wr_pend_r <= 1'b0;
            busy_r    <= 1'b0;
            twr_cnt_r <= 32'h0;
            oe_r      <= 1'b0;
            sda_o_r   <= 1'b0;
        end else if (busy_r) begin
            // R19 inputs ignored during write cycle
            // R4 no acknowledge while busy, since nothing is decoded
            oe_r <= 1'b0;
            st_r <= ST_IDLE;
            if (twr_cnt_r >= TWR_CYCLES - 1) begin
                busy_r    <= 1'b0;
                twr_cnt_r <= 32'h0;
            end else begin
                twr_cnt_r <= twr_cnt_r + 32'h1;
            end
        end else if (start_ev || stop_ev) begin
            // R21 start or stop aborts any byte in flight
            oe_r  <= 1'b0;
            bit_r <= 4'h0;
            st_r  <= start_ev ? ST_DEV : ST_IDLE;
            // R19 write cycle begins once the write transfer ends
            if (wr_pend_r) begin
                wr_pend_r <= 1'b0;
                busy_r    <= 1'b1;
                twr_cnt_r <= 32'h0;
                st_r      <= ST_IDLE;
            end
        end else if (st_r != ST_IDLE && scl_rise) begin
            bit_r <= bit_r + 4'h1;
            if (bit_r < `SEE_BIT_ACK) begin
                sh_r <= {sh_r[6:0], sda};
            end else if (st_r == ST_RDAT) begin
                // R12 controller acknowledge sampled on ninth clock
                mack_r <= oe_r ? 1'b0 : sda;
            end
        end else if (st_r != ST_IDLE && scl_fall) begin
            if (bit_r == `SEE_BIT_ACK) begin
                case (st_r)
                    ST_DEV: begin
                        // R16 address compare against straps
                        if (dev_match(sh_r, filt_r[4:2])) begin
                            // R17 acknowledge low on ninth clock
                            oe_r <= 1'b1;
                            // R5 direction bit one selects read
                            st_r <= sh_r[0] ? ST_RDAT : ST_AHI;
                        end else begin
                            oe_r <= 1'b0;
                            st_r <= ST_IDLE;
                        end
                    end
                    ST_AHI: begin
                        // R18 high word address byte first
                        addr_r[15:8] <= sh_r;
                        oe_r         <= 1'b1;
                        st_r         <= ST_ALO;
                    end
                    ST_ALO: begin
                        addr_r[7:0] <= sh_r;
                        oe_r        <= 1'b1;
                        st_r        <= ST_WDAT;
                    end
                    ST_WDAT: begin
                        // R1 R2 only the in-page bits advance, page wraps
                        addr_r[`SEE_PAGE_BITS-1:0] <= addr_r[`SEE_PAGE_BITS-1:0] + 7'h01;
                        wr_pend_r                  <= 1'b1;
                        oe_r                       <= 1'b1;
                    end
                    ST_RDAT: begin
                        // release for the controller acknowledge
                        oe_r <= 1'b0;
                    end
                    default: begin
                        oe_r <= 1'b0;
                        st_r <= ST_IDLE;
                    end
                endcase
            end else if (bit_r == `SEE_BIT_END) begin
                bit_r <= 4'h0;
                if (st_r == ST_RDAT) begin
                    if (!mack_r) begin
                        // R8 R13 send byte at counter, R6 R7 R14 counter wraps over memory
                        rd_r   <= rd_next;
                        oe_r   <= ~rd_next[7];
                        addr_r <= addr_r + 16'h0001;
                    end else begin
                        // R15 high acknowledge: stop driving and wait for stop
                        oe_r <= 1'b0;
                        st_r <= ST_IDLE;
                    end
                end else begin
                    oe_r <= 1'b0;
                end
            end else if (st_r == ST_RDAT) begin
                // shift out next bit, most significant first; pulled low by enable only
                oe_r <= ~rd_r[3'd7 - bit_r[2:0]];
            end
        end
    end

endmodule // see_ctrl
`default_nettype wire

/* verilog/see_defines.vh */
// constants for the two-wire serial memory access block
// Notes on behaviour
// R1: page write advances only the low seven address bits per data byte.
// R2: more than 128 data bytes wrap within the page and overwrite earlier bytes.
// R3: controller polls write end with start plus device address byte.
// R4: no acknowledge while write cycle runs; acknowledge low once it is finished.
// R5: direction bit one selects read; otherwise the transfer starts as a write.
// R6: address counter holds last accessed address plus one, kept across transfers.
// R7: read addressing wraps from last byte of memory to first byte.
// R8: after read address acknowledge, shift out byte at current counter address.
// R9: controller ends single read with high acknowledge then stop.
// R10: random read starts with write address and word address, no data.
// R11: after word address acknowledge controller sends repeated start, read address.
// R12: controller drives low acknowledge after each byte it wants continued.
// R13: low acknowledge after a read byte increments address, sends next byte.
// R14: sequential read wraps at memory top and keeps sending.
// R15: high acknowledge then stop ends sequential read; device releases data line.
// R16: device address is 1010, three select bits matching straps, direction bit.
// R17: device acknowledges each received byte by pulling data low on ninth clock.
// R18: write carries two word address bytes, high first, before data.
// R19: after write stop, all bus inputs ignored until write cycle completes.
// R20: word address counter is 16 bits: 512 pages of 128 bytes.
// R21: start or stop inside a byte aborts the transfer.
`ifndef SEE_DEFINES_VH
`define SEE_DEFINES_VH

// ==========================================================
// device address and memory shape
`define SEE_DEV_PREFIX   4'hA
`define SEE_ADDR_W       16
`define SEE_MEM_DEPTH    65536
`define SEE_PAGE_BITS    7

// ==========================================================
// timing
`define SEE_CLK_MHZ      100
`define SEE_TWR_US       5000

// ==========================================================
// address reset value and bit counter positions
`define SEE_ADDR_RST     16'h0000
`define SEE_BIT_ACK      4'h8
`define SEE_BIT_END      4'h9

`endif

/* sim/see_ctrl_sva.sv */
// assertion checker for the two-wire serial memory slave
`default_nettype none
module see_ctrl_sva #(
    parameter integer TWR_CYCLES = 50
) (
    input wire logic       I_CLK_SYS,
    input wire logic       I_SYS_RST,
    input wire logic       I_SCL,
    input wire logic       I_SDA,
    input wire logic [2:0] I_ADDRESS_SELECT_STRAPS,
    input wire logic       O_SDA_OUT,
    input wire logic       O_SDA_OE,
    input wire logic       O_WRITE_BUSY
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================
    // busy length counter, too long for a repetition
    integer busy_cnt_r;
    always @(posedge I_CLK_SYS) busy_cnt_r <= (I_SYS_RST || !O_WRITE_BUSY) ? 0 : busy_cnt_r + 1;
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SYS_RST);
    a_out_low: assert property (!O_SDA_OUT) else $error("data output not low");
    a_busy_no_ack: assert property (O_WRITE_BUSY |-> !O_SDA_OE) else $error("driven while busy");
    a_busy_len: assert property ($fell(O_WRITE_BUSY) |-> busy_cnt_r == TWR_CYCLES) else $error("busy length");
    a_oe_scl_low: assert property ($changed(O_SDA_OE) |-> !I_SCL) else $error("data moved with clock high");
    a_busy_stop: assert property ($rose(O_WRITE_BUSY) |-> I_SCL && I_SDA) else $error("busy without stop");
    a_oe_hold: assert property ($rose(O_SDA_OE) |=> O_SDA_OE[*8]) else $error("low bit too short");
    a_busy_hold: assert property ($rose(O_WRITE_BUSY) |=> O_WRITE_BUSY[*8]) else $error("busy dropped");
    a_rst_quiet: assert property (disable iff (1'b0) I_SYS_RST |=> !O_SDA_OE && !O_WRITE_BUSY)
        else $error("outputs active in reset");
endmodule // see_ctrl_sva
bind see_ctrl see_ctrl_sva #(.TWR_CYCLES(TWR_CYCLES)) chk_u (.I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST),
    .I_SCL(I_SCL), .I_SDA(I_SDA), .I_ADDRESS_SELECT_STRAPS(I_ADDRESS_SELECT_STRAPS),
    .O_SDA_OUT(O_SDA_OUT), .O_SDA_OE(O_SDA_OE), .O_WRITE_BUSY(O_WRITE_BUSY));
`default_nettype wire

/* sim/see_host_model.sv */
// two-wire bus controller model: start, stop, byte out, byte in
`default_nettype none
module see_host_model (
    output var logic o_scl,
    output var logic o_sda,
    input  wire logic i_sda
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================
    // clock stands high outside frames, data released to pull-up
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic start;
        o_sda = 1'b1;
        #40 o_scl = 1'b1;
        #40 o_sda = 0;
        #40 o_scl = 0;
        #40;
    endtask
    task automatic stop;
        o_sda = 0;
        #40 o_scl = 1'b1;
        #40 o_sda = 1'b1;
        #40;
    endtask
    task automatic bit_x(input logic b, output logic r);
        o_sda = b;
        #40 o_scl = 1'b1;
        #40 r = i_sda;
        #40 o_scl = 0;
        #40;
    endtask
    // msb first, ninth clock released for acknowledge
    task automatic put(input logic [7:0] d, output logic [7:0] a);
        logic r;
        for (int k = 7; k >= 0; k--) bit_x(d[k], r);
        bit_x(1'b1, r);
        a = {7'h00, r};
    endtask
    task automatic get(output logic [7:0] d, input logic a);
        logic r;
        for (int k = 7; k >= 0; k--) begin
            bit_x(1'b1, r);
            d[k] = r;
        end
        bit_x(a, r);
    endtask
endmodule // see_host_model
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench for the two-wire serial memory slave
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [6:0] DEV = 7'h55; // 1010 then straps 101
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [2:0]  straps = 3'h5;
    wire         scl, host_sda, sda_out, sda_oe, busy;
    wire         sda_bus = host_sda & ~(sda_oe & ~sda_out);
    integer      err_total = 0, comparisons = 0;
    logic [7:0]  ack, rd;
    logic [23:0] rows [0:3] = '{24'hFFFFA5, 24'h00003C, 24'h0001C3, 24'h12340F};
    always #5 clk = ~clk;
    see_host_model host_u (.o_scl(scl), .o_sda(host_sda), .i_sda(sda_bus));
    see_ctrl #(.TWR_CYCLES(300)) dut_u (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_SCL(scl), .I_SDA(sda_bus),
        .I_ADDRESS_SELECT_STRAPS(straps), .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .O_WRITE_BUSY(busy));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic addr(input logic [15:0] a);
        host_u.start();
        host_u.put({DEV, 1'b0}, ack); chk(ack, 8'h00);
        host_u.put(a[15:8], ack); chk(ack, 8'h00);
        host_u.put(a[7:0], ack); chk(ack, 8'h00);
    endtask
    task automatic rd_start;
        host_u.start();
        host_u.put({DEV, 1'b1}, ack); chk(ack, 8'h00);
    endtask
    task automatic wait_idle;
        // the stop reaches the write timer only after the input filter, so let it through first
        repeat (8) @(posedge clk);
        #1;
        chk({7'h00, busy}, 8'h01);
        for (int n = 0; n < 400 && busy !== 1'b0; n++) @(posedge clk);
        chk({7'h00, busy}, 8'h00);
        #1;
    endtask
    task automatic print_verdict;
        $display("err_total=%0d comparisons=%0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        $display("Error %0t: timeout", $time);
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk({6'h00, sda_oe, busy}, 8'h00);
        // ==========================================
        // rows: byte write then random read back
        for (int r = 0; r < 4; r++) begin
            addr(rows[r][23:8]);
            host_u.put(rows[r][7:0], ack); chk(ack, 8'h00);
            host_u.stop();
            wait_idle();
        end
        for (int r = 0; r < 4; r++) begin
            addr(rows[r][23:8]);
            rd_start();
            host_u.get(rd, 1'b1); chk(rd, rows[r][7:0]);
            host_u.stop();
        end
        // ==========================================
        // sequential read across the top, then current address
        addr(16'hFFFF);
        rd_start();
        host_u.get(rd, 1'b0); chk(rd, 8'hA5);
        host_u.get(rd, 1'b1); chk(rd, 8'h3C);
        host_u.stop();
        rd_start();
        host_u.get(rd, 1'b1); chk(rd, 8'hC3);
        host_u.stop();
        // ==========================================
        // page wrap, poll refused while busy
        addr(16'h017E);
        host_u.put(8'h11, ack);
        host_u.put(8'h22, ack);
        host_u.put(8'h33, ack); chk(ack, 8'h00);
        host_u.stop();
        host_u.start();
        host_u.put({DEV, 1'b0}, ack); chk(ack, 8'h01);
        host_u.stop();
        wait_idle();
        addr(16'h0100);
        rd_start();
        host_u.get(rd, 1'b1); chk(rd, 8'h33);
        host_u.stop();
        addr(16'h017E);
        rd_start();
        host_u.get(rd, 1'b0); chk(rd, 8'h11);
        host_u.get(rd, 1'b1); chk(rd, 8'h22);
        host_u.stop();
        // ==========================================
        // straps mismatch is not acknowledged
        host_u.start();
        host_u.put({4'hA, 3'h2, 1'b0}, ack); chk(ack, 8'h01);
        host_u.stop();
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
